// >>> rtl/sfe_dev.sv
`timescale 1ns/1ns
module sfe_dev
	import sfe_pkg::*;
#(
	parameter logic [31:0] SSE_CYC = SSE_CYC_DEF,
	parameter logic [31:0] SE_CYC = SE_CYC_DEF,
	parameter logic [31:0] BE_CYC = BE_CYC_DEF,
	parameter logic [31:0] PP_CYC = PP_CYC_DEF,
	parameter logic [31:0] SUSP_CYC = SUSP_CYC_DEF
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	sfe_if.dev link,
	input wire logic [1:0] i_proto,
	input wire logic [255:0] i_lock_bits,
	input wire logic i_op_timeout,
	output logic o_mem_op,
	output sfe_kind_e o_mem_kind,
	output logic [23:0] o_mem_addr,
	output logic [7:0] o_mem_data,
	output logic [7:0] o_status,
	output logic [7:0] o_flag_status
);
	logic [5:0] s1_r, s2_r, s3_r, f_r, fd_r;
	logic [5:0] agree;
	logic cs_n, rise, fall, cs_fall, cs_up;
	logic [39:0] sh_r, sh_nxt;
	logic [5:0] bcnt_r, bcnt_nxt;
	logic [2:0] ph_r, w;
	logic [7:0] op_r, op_new;
	logic cap;
	logic rd_arm_r, rd_act_r;
	logic [7:0] out_r;
	logic wel_r, run_r, spend_r, es_v_r, ps_v_r;
	sfe_kind_e kind_r, es_kind_r, er_kind;
	logic [31:0] cnt_r, scnt_r, es_cnt_r, ps_cnt_r, er_cyc;
	logic [23:0] addr_r, es_addr_r, ps_addr_r, addr_in;
	logic [7:0] data_r, ps_data_r;
	logic [6:0] fsr_r;
	logic cmd_go, is_erase, is_prog, lock_hit, sus_hit;

	// Pin synchroniser and agreement filter
	assign agree = ~(s2_r ^ s3_r);
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			s1_r <= 6'h2F;
			s2_r <= 6'h2F;
			s3_r <= 6'h2F;
			f_r <= 6'h2F;
			fd_r <= 6'h2F;
		end else begin
			s1_r <= {link.cs_n, link.sclk, link.dq};
			s2_r <= s1_r;
			s3_r <= s2_r;
			f_r <= (agree & s3_r) | (~agree & f_r);
			fd_r <= f_r;
		end
	end
	assign cs_n = f_r[5];
	assign rise = f_r[4] & ~fd_r[4] & ~cs_n;
	assign fall = ~f_r[4] & fd_r[4] & ~cs_n;
	assign cs_fall = ~cs_n & fd_r[5];
	assign cs_up = cs_n & ~fd_r[5];

	// Bits per clock by line count
	always_comb begin
		case (i_proto)
			PROTO_DUAL: begin
				w = 3'h2;
				sh_nxt = {sh_r[37:0], f_r[1:0]};
			end
			PROTO_QUAD: begin
				w = 3'h4;
				sh_nxt = {sh_r[35:0], f_r[3:0]};
			end
			default: begin
				w = 3'h1;
				sh_nxt = {sh_r[38:0], f_r[0]};
			end
		endcase
		bcnt_nxt = bcnt_r + {3'h0, w};
	end
	assign op_new = sh_nxt[7:0];
	assign cap = rise && (bcnt_r < BITS_OP) && (bcnt_nxt == BITS_OP);

	// Frame shifter; bits latched on rising link clock
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			sh_r <= 40'h0;
			bcnt_r <= 6'h0;
			ph_r <= 3'h0;
			op_r <= 8'h0;
		end else if (cs_fall) begin
			bcnt_r <= 6'h0;
			ph_r <= 3'h0;
		end else if (rise) begin
			ph_r <= ph_r + w;
			if (bcnt_r < BITS_MAX) begin
				sh_r <= sh_nxt;
				bcnt_r <= bcnt_nxt;
			end
			if (cap) begin
				op_r <= op_new;
			end
		end
	end

	// Register readout on line 1, shifted on falling link clock
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			rd_arm_r <= 1'b0;
			rd_act_r <= 1'b0;
			out_r <= 8'h0;
		end else if (cs_n) begin
			rd_arm_r <= 1'b0;
			rd_act_r <= 1'b0;
		end else if (cap && (op_new == OP_RDSR || op_new == OP_RDFSR)) begin
			rd_arm_r <= 1'b1;
		end else if (fall && rd_arm_r) begin
			out_r <= (op_r == OP_RDSR) ? o_status : o_flag_status;
			rd_arm_r <= 1'b0;
			rd_act_r <= 1'b1;
		end else if (fall && rd_act_r) begin
			out_r <= {out_r[6:0], out_r[7]};
		end
	end
	assign link.dev_dq_o = {2'h0, out_r[7], 1'b0};
	assign link.dev_dq_oe_n = {2'h3, ~rd_act_r, 1'b1};

	always_comb begin
		o_status = 8'h0;
		o_status[SR_WIP] = run_r;
		o_status[SR_WEL] = wel_r;
		o_flag_status = {1'b0, fsr_r};
		o_flag_status[FSR_READY] = ~run_r;
	end

	// Command decode, valid only on a byte boundary
	assign cmd_go = cs_up && (ph_r == 3'h0);
	assign addr_in = (bcnt_r == BITS_MAX) ? sh_r[31:8] : sh_r[23:0];
	always_comb begin
		is_erase = 1'b0;
		er_kind = SFE_K_SUB;
		er_cyc = SSE_CYC;
		if (bcnt_r == BITS_ADDR && (op_r == OP_SSE_A || op_r == OP_SSE_B)) begin
			is_erase = 1'b1;
		end else if (bcnt_r == BITS_ADDR && op_r == OP_SE) begin
			is_erase = 1'b1;
			er_kind = SFE_K_SEC;
			er_cyc = SE_CYC;
		end else if (bcnt_r == BITS_OP && (op_r == OP_BE_A || op_r == OP_BE_B)) begin
			is_erase = 1'b1;
			er_kind = SFE_K_BULK;
			er_cyc = BE_CYC;
		end
	end
	assign is_prog = (bcnt_r == BITS_MAX) && (op_r == OP_PP);
	assign lock_hit = (er_kind == SFE_K_BULK && is_erase) ? |i_lock_bits
		: i_lock_bits[addr_in[23:SEC_LSB]];
	assign sus_hit = es_v_r && (es_kind_r == SFE_K_BULK
		|| es_addr_r[23:SEC_LSB] == addr_in[23:SEC_LSB]);

	// Operation engine with one-deep suspend nesting
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			wel_r <= 1'b0;
			fsr_r <= FSR_RESET[6:0];
			run_r <= 1'b0;
			spend_r <= 1'b0;
			es_v_r <= 1'b0;
			ps_v_r <= 1'b0;
			kind_r <= SFE_K_SUB;
			es_kind_r <= SFE_K_SUB;
			cnt_r <= 32'h0;
			scnt_r <= 32'h0;
			es_cnt_r <= 32'h0;
			ps_cnt_r <= 32'h0;
			addr_r <= 24'h0;
			es_addr_r <= 24'h0;
			ps_addr_r <= 24'h0;
			data_r <= 8'h0;
			ps_data_r <= 8'h0;
			o_mem_op <= 1'b0;
			o_mem_kind <= SFE_K_SUB;
			o_mem_addr <= 24'h0;
			o_mem_data <= 8'h0;
		end else begin
			o_mem_op <= 1'b0;
			if (cmd_go) begin
				if (bcnt_r == BITS_OP && op_r == OP_WREN) begin
					wel_r <= 1'b1;
				end else if (bcnt_r == BITS_OP && op_r == OP_CLFSR) begin
					fsr_r[FSR_EERR] <= 1'b0;
					fsr_r[FSR_PERR] <= 1'b0;
					fsr_r[FSR_PROT] <= 1'b0;
				end else if (bcnt_r == BITS_OP && op_r == OP_SUSP) begin
					if (run_r && !spend_r && cnt_r > 32'h1) begin
						spend_r <= 1'b1;
						scnt_r <= SUSP_CYC;
						fsr_r[kind_r == SFE_K_PROG ? FSR_PSUS : FSR_ESUS] <= 1'b1;
					end
				end else if (bcnt_r == BITS_OP && op_r == OP_RES) begin
					if (!run_r && ps_v_r) begin
						run_r <= 1'b1;
						kind_r <= SFE_K_PROG;
						cnt_r <= ps_cnt_r;
						addr_r <= ps_addr_r;
						data_r <= ps_data_r;
						ps_v_r <= 1'b0;
						fsr_r[FSR_PSUS] <= 1'b0;
					end else if (!run_r && es_v_r) begin
						run_r <= 1'b1;
						kind_r <= es_kind_r;
						cnt_r <= es_cnt_r;
						addr_r <= es_addr_r;
						es_v_r <= 1'b0;
						fsr_r[FSR_ESUS] <= 1'b0;
					end
				end else if (is_erase && wel_r && !run_r && !es_v_r && !ps_v_r) begin
					if (lock_hit) begin
						fsr_r[FSR_PROT] <= 1'b1;
						fsr_r[FSR_EERR] <= 1'b1;
					end else begin
						run_r <= 1'b1;
						kind_r <= er_kind;
						cnt_r <= er_cyc;
						addr_r <= addr_in;
					end
				end else if (is_prog && wel_r && !run_r && !ps_v_r) begin
					if (sus_hit) begin
						fsr_r[FSR_PERR] <= 1'b1;
					end else if (lock_hit) begin
						fsr_r[FSR_PROT] <= 1'b1;
						fsr_r[FSR_PERR] <= 1'b1;
					end else begin
						run_r <= 1'b1;
						kind_r <= SFE_K_PROG;
						cnt_r <= PP_CYC;
						addr_r <= addr_in;
						data_r <= sh_r[7:0];
					end
				end
			end
			if (run_r) begin
				cnt_r <= cnt_r - 32'h1;
				if (i_op_timeout && kind_r != SFE_K_PROG) begin
					run_r <= 1'b0;
					wel_r <= 1'b0;
					spend_r <= 1'b0;
					fsr_r[FSR_EERR] <= 1'b1;
					fsr_r[FSR_ESUS] <= 1'b0;
				end else if (cnt_r <= 32'h1) begin
					run_r <= 1'b0;
					wel_r <= 1'b0;
					spend_r <= 1'b0;
					if (spend_r) begin
						fsr_r[kind_r == SFE_K_PROG ? FSR_PSUS : FSR_ESUS] <= 1'b0;
					end
					o_mem_op <= 1'b1;
					o_mem_kind <= kind_r;
					o_mem_data <= (kind_r == SFE_K_PROG) ? data_r : ERASE_FILL;
					case (kind_r)
						SFE_K_SUB: o_mem_addr <= addr_r & SUB_MASK;
						SFE_K_SEC: o_mem_addr <= addr_r & SEC_MASK;
						SFE_K_BULK: o_mem_addr <= 24'h0;
						default: o_mem_addr <= addr_r;
					endcase
				end else if (spend_r && scnt_r <= 32'h1) begin
					run_r <= 1'b0;
					spend_r <= 1'b0;
					if (kind_r == SFE_K_PROG) begin
						ps_v_r <= 1'b1;
						ps_cnt_r <= cnt_r;
						ps_addr_r <= addr_r;
						ps_data_r <= data_r;
					end else begin
						es_v_r <= 1'b1;
						es_kind_r <= kind_r;
						es_cnt_r <= cnt_r;
						es_addr_r <= addr_r;
					end
				end else if (spend_r) begin
					scnt_r <= scnt_r - 32'h1;
				end
			end
		end
	end
endmodule // sfe_dev

// >>> shared/sfe_pkg.sv
package sfe_pkg;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_RDFSR = 8'h70;
	localparam logic [7:0] OP_CLFSR = 8'h50;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_SSE_A = 8'h52;
	localparam logic [7:0] OP_SSE_B = 8'h20;
	localparam logic [7:0] OP_SE = 8'hD8;
	localparam logic [7:0] OP_BE_A = 8'hC7;
	localparam logic [7:0] OP_BE_B = 8'h60;
	localparam logic [7:0] OP_SUSP = 8'h75;
	localparam logic [7:0] OP_RES = 8'h7A;
	localparam int FSR_READY = 7;
	localparam int FSR_ESUS = 6;
	localparam int FSR_EERR = 5;
	localparam int FSR_PERR = 4;
	localparam int FSR_PSUS = 2;
	localparam int FSR_PROT = 1;
	localparam logic [7:0] FSR_RESET = 8'h80;
	localparam int SR_WIP = 0;
	localparam int SR_WEL = 1;
	localparam logic [7:0] ERASE_FILL = 8'hFF;
	localparam logic [23:0] SUB_MASK = 24'hFFF000;
	localparam logic [23:0] SEC_MASK = 24'hFF0000;
	localparam int SEC_LSB = 16;
	localparam logic [1:0] PROTO_SINGLE = 2'h0;
	localparam logic [1:0] PROTO_DUAL = 2'h1;
	localparam logic [1:0] PROTO_QUAD = 2'h2;
	localparam logic [5:0] BITS_OP = 6'h08;
	localparam logic [5:0] BITS_ADDR = 6'h20;
	localparam logic [5:0] BITS_MAX = 6'h28;
	localparam int CLK_MHZ = 25;
	localparam int SSE_TIME_US = 400;
	localparam int SE_TIME_US = 700;
	localparam int BE_TIME_US = 2000;
	localparam int PP_TIME_US = 120;
	localparam int SUSP_LAT_US = 40;
	localparam logic [31:0] SSE_CYC_DEF = 32'(SSE_TIME_US * CLK_MHZ);
	localparam logic [31:0] SE_CYC_DEF = 32'(SE_TIME_US * CLK_MHZ);
	localparam logic [31:0] BE_CYC_DEF = 32'(BE_TIME_US * CLK_MHZ);
	localparam logic [31:0] PP_CYC_DEF = 32'(PP_TIME_US * CLK_MHZ);
	localparam logic [31:0] SUSP_CYC_DEF = 32'(SUSP_LAT_US * CLK_MHZ);
	localparam logic [3:0] SCLK_HALF = 4'h8;
	typedef enum logic [1:0] {SFE_K_SUB, SFE_K_SEC, SFE_K_BULK, SFE_K_PROG} sfe_kind_e;
endpackage

// >>> shared/sfe_if.sv
`timescale 1ns/1ns
interface sfe_if;
	logic cs_n;
	logic sclk;
	logic [3:0] host_dq_o;
	logic [3:0] host_dq_oe_n;
	logic [3:0] dev_dq_o;
	logic [3:0] dev_dq_oe_n;
	logic [3:0] dq;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_wire
			// Pulled high when nobody drives
			assign dq[g] = !host_dq_oe_n[g] ? host_dq_o[g] : (!dev_dq_oe_n[g] ? dev_dq_o[g] : 1'b1);
		end
	endgenerate
	modport host (output cs_n, output sclk, output host_dq_o, output host_dq_oe_n, input dq);
	modport dev (input cs_n, input sclk, input dq, output dev_dq_o, output dev_dq_oe_n);
endinterface

// >>> rtl/sfe_host.sv
`timescale 1ns/1ns
module sfe_host
	import sfe_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rstn,
	sfe_if.host link,
	input wire logic [1:0] i_proto,
	input wire logic i_cmd_valid,
	input wire logic [7:0] i_cmd_op,
	input wire logic [23:0] i_cmd_addr,
	input wire logic [7:0] i_cmd_data,
	output logic o_cmd_ready,
	output logic o_done,
	output logic [7:0] o_rdata,
	output logic o_suspended
);
	typedef enum logic [1:0] {H_IDLE, H_SEND, H_GAP} sfe_hst_e;
	sfe_hst_e st_r;
	logic [3:0] hc_r;
	logic sclk_r, cs_n_r, pend_r;
	logic [39:0] tx_r;
	logic [5:0] txc_r;
	logic [3:0] rxc_r;
	logic [7:0] rx_r, op_r, mop_r;
	logic [23:0] addr_r;
	logic [7:0] data_r;
	logic [2:0] s_r;
	logic d1_r;
	logic [2:0] w;
	logic [5:0] mlen;
	logic half, last;

	always_comb begin
		case (i_proto)
			PROTO_DUAL: w = 3'h2;
			PROTO_QUAD: w = 3'h4;
			default: w = 3'h1;
		endcase
		case (mop_r)
			OP_PP: mlen = BITS_MAX;
			OP_SSE_A, OP_SSE_B, OP_SE: mlen = BITS_ADDR;
			default: mlen = BITS_OP;
		endcase
	end

	// Line 1 read-back synchroniser
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			s_r <= 3'h7;
			d1_r <= 1'b1;
		end else begin
			s_r <= {s_r[1:0], link.dq[1]};
			if (s_r[1] == s_r[2]) begin
				d1_r <= s_r[2];
			end
		end
	end

	assign half = (hc_r == SCLK_HALF - 4'h1);
	assign last = (txc_r == {3'h0, w} && rxc_r == 4'h0) || (txc_r == 6'h0 && rxc_r == 4'h1);
	assign o_cmd_ready = (st_r == H_IDLE);

	// Frame sequencer; the link clock is divided down here
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			st_r <= H_IDLE;
			hc_r <= 4'h0;
			sclk_r <= 1'b0;
			cs_n_r <= 1'b1;
			pend_r <= 1'b0;
			tx_r <= 40'h0;
			txc_r <= 6'h0;
			rxc_r <= 4'h0;
			rx_r <= 8'h0;
			op_r <= 8'h0;
			mop_r <= 8'h0;
			addr_r <= 24'h0;
			data_r <= 8'h0;
			o_done <= 1'b0;
			o_rdata <= 8'h0;
			o_suspended <= 1'b0;
		end else begin
			o_done <= 1'b0;
			hc_r <= half ? 4'h0 : hc_r + 4'h1;
			case (st_r)
				H_IDLE: begin
					hc_r <= 4'h0;
					if (i_cmd_valid) begin
						mop_r <= i_cmd_op;
						addr_r <= i_cmd_addr;
						data_r <= i_cmd_data;
						st_r <= H_GAP;
						// Erase and program get a write enable frame first
						pend_r <= 1'b1;
						op_r <= 8'h0;
						if (i_cmd_op == OP_PP || i_cmd_op == OP_SSE_A || i_cmd_op == OP_SSE_B
							|| i_cmd_op == OP_SE || i_cmd_op == OP_BE_A || i_cmd_op == OP_BE_B) begin
							op_r <= OP_WREN;
							tx_r <= {OP_WREN, 32'h0};
							txc_r <= BITS_OP;
							rxc_r <= 4'h0;
							pend_r <= 1'b1;
							cs_n_r <= 1'b0;
							st_r <= H_SEND;
						end
					end
				end
				H_SEND: begin
					if (half && !sclk_r) begin
						sclk_r <= 1'b1;
					end else if (half) begin
						sclk_r <= 1'b0;
						if (txc_r != 6'h0) begin
							tx_r <= tx_r << w;
							txc_r <= txc_r - {3'h0, w};
						end else begin
							rx_r <= {rx_r[6:0], d1_r};
							rxc_r <= rxc_r - 4'h1;
						end
						if (last) begin
							cs_n_r <= 1'b1;
							st_r <= H_GAP;
						end
					end
				end
				H_GAP: begin
					if (half && pend_r) begin
						pend_r <= 1'b0;
						op_r <= mop_r;
						tx_r <= {mop_r, addr_r, data_r};
						txc_r <= mlen;
						rxc_r <= (mop_r == OP_RDSR || mop_r == OP_RDFSR) ? 4'h8 : 4'h0;
						cs_n_r <= 1'b0;
						st_r <= H_SEND;
					end else if (half) begin
						o_done <= 1'b1;
						o_rdata <= rx_r;
						if (op_r == OP_RDFSR) begin
							o_suspended <= rx_r[FSR_READY] & (rx_r[FSR_ESUS] | rx_r[FSR_PSUS]);
						end else if (op_r == OP_RES) begin
							o_suspended <= 1'b0;
						end
						st_r <= H_IDLE;
					end
				end
				default: st_r <= H_IDLE;
			endcase
		end
	end

	// Only register reads are issued, never array reads
	assign link.cs_n = cs_n_r;
	assign link.sclk = sclk_r;
	always_comb begin
		if (st_r != H_SEND || txc_r == 6'h0) begin
			link.host_dq_o = 4'h0;
			link.host_dq_oe_n = 4'hF;
		end else begin
			case (i_proto)
				PROTO_DUAL: begin
					link.host_dq_o = {2'h0, tx_r[39:38]};
					link.host_dq_oe_n = 4'hC;
				end
				PROTO_QUAD: begin
					link.host_dq_o = tx_r[39:36];
					link.host_dq_oe_n = 4'h0;
				end
				default: begin
					link.host_dq_o = {3'h0, tx_r[39]};
					link.host_dq_oe_n = 4'hE;
				end
			endcase
		end
	end
endmodule // sfe_host

// >>> test/sfe_checker.sv
`timescale 1ns/1ns
module sfe_checker (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] host_dq_o,
	input wire logic [3:0] host_dq_oe_n,
	input wire logic [3:0] dev_dq_o,
	input wire logic [3:0] dev_dq_oe_n,
	input wire logic [3:0] dq
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);

	a_idle_clock_low: assert property (cs_n && $past(cs_n) |-> !sclk)
		else $error("link clock moves outside a frame");
	a_cs_rise_after_fall: assert property ($rose(cs_n) |-> !sclk)
		else $error("chip select rose while link clock high");
	a_high_half_exact: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
		else $error("link clock high phase not eight cycles");
	a_low_half_min: assert property ($fell(sclk) |-> !sclk [*8])
		else $error("link clock low phase too short");
	a_host_data_hold: assert property ($rose(sclk) |-> $stable(host_dq_o) [*8])
		else $error("host data moved while link clock high");
	a_no_contention: assert property ((~host_dq_oe_n & ~dev_dq_oe_n) == 4'h0)
		else $error("both ends drive one data line");
	a_dev_one_line: assert property (dev_dq_oe_n[0] && dev_dq_oe_n[2] && dev_dq_oe_n[3])
		else $error("device drives a line other than line one");
	a_dev_released: assert property (cs_n [*8] |-> dev_dq_oe_n[1])
		else $error("device still drives after deselect");
	a_dev_out_low: assert property (!dev_dq_oe_n[1] && !$past(dev_dq_oe_n[1]) && $changed(dev_dq_o[1]) |-> !sclk)
		else $error("device output changed while link clock high");
	a_read_line: assert property (!dev_dq_oe_n[1] |-> dq[1] == dev_dq_o[1])
		else $error("read line does not carry device output");
endmodule // sfe_checker

// >>> test/testbench.sv
`timescale 1ns/1ns
module testbench;
	import sfe_pkg::*;
	localparam logic [7:0] EOPS [5] = '{OP_SSE_A, OP_SSE_B, OP_SE, OP_BE_A, OP_BE_B};
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [1:0] proto = 2'h0;
	logic valid = 1'b0;
	logic [7:0] op = 8'h00;
	logic [23:0] addr = 24'h000000;
	logic [7:0] wdat = 8'h00;
	logic [255:0] lock = '0;
	logic tmo = 1'b0;
	logic rdy, done, susp, mem_op;
	logic [7:0] rdata, st, fst, mem_data;
	logic [23:0] mem_addr, a, b;
	logic [7:0] pd;
	logic [1:0] kk;
	sfe_kind_e mem_kind;
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [15:0] rd_q [$];
	logic [33:0] mem_q [$];

	sfe_if link ();
	sfe_host u_sfe_host (.i_core_clk(clk), .i_rstn(rstn), .link(link), .i_proto(proto), .i_cmd_valid(valid),
		.i_cmd_op(op), .i_cmd_addr(addr), .i_cmd_data(wdat), .o_cmd_ready(rdy), .o_done(done), .o_rdata(rdata),
		.o_suspended(susp));
	sfe_dev #(.SSE_CYC(32'h7D0), .SE_CYC(32'h9C4), .BE_CYC(32'hBB8), .PP_CYC(32'h5DC), .SUSP_CYC(32'h190))
		u_sfe_dev (.i_core_clk(clk), .i_rstn(rstn), .link(link), .i_proto(proto), .i_lock_bits(lock),
		.i_op_timeout(tmo), .o_mem_op(mem_op), .o_mem_kind(mem_kind), .o_mem_addr(mem_addr),
		.o_mem_data(mem_data), .o_status(st), .o_flag_status(fst));
	sfe_checker u_sfe_checker (.i_core_clk(clk), .i_rstn(rstn), .cs_n(link.cs_n), .sclk(link.sclk),
		.host_dq_o(link.host_dq_o), .host_dq_oe_n(link.host_dq_oe_n), .dev_dq_o(link.dev_dq_o),
		.dev_dq_oe_n(link.dev_dq_oe_n), .dq(link.dq));

	always #20 clk = ~clk;

	task automatic results;
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic fail(input string s);
		errors++;
		$display("Error at %0t: %s", $time, s);
	endtask

	task automatic check_rd(input logic [7:0] got, input logic [15:0] n);
		samples_checked++;
		if ((got & n[7:0]) !== (n[15:8] & n[7:0])) fail($sformatf("read %h expected %h", got, n[15:8]));
	endtask

	task automatic check_susp(input logic e);
		samples_checked++;
		if (susp !== e) fail($sformatf("suspended %b expected %b", susp, e));
	endtask

	task automatic check_mem(input logic [33:0] got, input logic [33:0] e);
		samples_checked++;
		if (got !== e) fail($sformatf("memory op %h expected %h", got, e));
	endtask

	// Result watcher
	always @(negedge clk) begin
		if (done === 1'b1 && rd_q.size() > 0) begin
			if (rd_q[0][7:0] != 8'h00) check_rd(rdata, rd_q[0]);
			void'(rd_q.pop_front());
		end
		if (mem_op === 1'b1) begin
			if (mem_q.size() == 0) fail("unexpected memory op");
			else check_mem({mem_kind, mem_addr, mem_data}, mem_q.pop_front());
		end
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 95000) begin
			fail("timeout");
			results();
		end
	end

	task automatic cmd(input logic [7:0] o, input logic [23:0] ad, input logic [7:0] d, input logic [7:0] e,
		input logic [7:0] m);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 4000);
		@(posedge clk);
		valid <= 1'b1;
		op <= o;
		addr <= ad;
		wdat <= d;
		proto <= 2'($urandom_range(2));
		rd_q.push_back({e, m});
		@(posedge clk);
		valid <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (done !== 1'b1 && n < 4000);
		if (n >= 4000) fail("request not finished");
	endtask

	task automatic rd(input logic [7:0] o, input logic [7:0] e, input logic [7:0] m);
		cmd(o, 24'h000000, 8'h00, e, m);
	endtask

	task automatic wait_mem;
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (mem_op !== 1'b1 && n < 6000);
		if (n >= 6000) fail("memory op missing");
	endtask

	task automatic idle(input int c);
		repeat (c) @(posedge clk);
	endtask

	initial begin
		void'($urandom(35));
		idle(6);
		rstn <= 1'b1;
		idle(6);
		rd(OP_RDFSR, FSR_RESET, 8'hFF);
		rd(OP_RDSR, 8'h00, 8'hFF);
		cmd(OP_RES, 24'h000000, 8'h00, 8'h00, 8'h00);
		rd(OP_RDFSR, FSR_RESET, 8'hFF);
		$display("test reset and idle resume done");
		for (int i = 0; i < 5; i++) begin
			a = 24'($urandom);
			b = i < 2 ? a & SUB_MASK : (i == 2 ? a & SEC_MASK : 24'h000000);
			kk = i < 2 ? SFE_K_SUB : (i == 2 ? SFE_K_SEC : SFE_K_BULK);
			mem_q.push_back({kk, b, ERASE_FILL});
			cmd(EOPS[i], a, 8'h00, 8'h00, 8'h00);
			rd(OP_RDFSR, 8'h00, 8'hB2);
			rd(OP_RDSR, 8'h03, 8'h03);
			wait_mem();
			rd(OP_RDSR, 8'h00, 8'h03);
			rd(OP_RDFSR, FSR_RESET, 8'hFF);
		end
		$display("test erase kinds done");
		a = 24'($urandom);
		@(posedge clk);
		lock[a[23:16]] <= 1'b1;
		cmd(OP_SSE_A, a, 8'h00, 8'h00, 8'h00);
		rd(OP_RDFSR, 8'hA2, 8'hFF);
		rd(OP_RDSR, 8'h02, 8'hFF);
		rd(OP_CLFSR, 8'h00, 8'h00);
		cmd(OP_BE_B, a, 8'h00, 8'h00, 8'h00);
		rd(OP_RDFSR, 8'hA2, 8'hFF);
		rd(OP_CLFSR, 8'h00, 8'h00);
		@(posedge clk);
		lock[a[23:16]] <= 1'b0;
		$display("test locked erase done");
		cmd(OP_SE, a, 8'h00, 8'h00, 8'h00);
		@(posedge clk);
		tmo <= 1'b1;
		idle(4);
		tmo <= 1'b0;
		rd(OP_RDFSR, 8'hA0, 8'hFF);
		rd(OP_RDSR, 8'h00, 8'hFF);
		rd(OP_CLFSR, 8'h00, 8'h00);
		$display("test erase timeout done");
		a = 24'($urandom);
		b = a ^ 24'h010000;
		pd = 8'($urandom);
		cmd(OP_SE, a, 8'h00, 8'h00, 8'h00);
		cmd(OP_SUSP, 24'h000000, 8'h00, 8'h00, 8'h00);
		rd(OP_RDFSR, 8'h40, 8'h7F);
		check_susp(1'b0);
		idle(200);
		rd(OP_RDFSR, 8'hC0, 8'hFF);
		check_susp(1'b1);
		cmd(OP_PP, a, pd, 8'h00, 8'h00);
		rd(OP_RDFSR, 8'hD0, 8'hFF);
		rd(OP_CLFSR, 8'h00, 8'h00);
		mem_q.push_back({SFE_K_PROG, b, pd});
		mem_q.push_back({SFE_K_SEC, a & SEC_MASK, ERASE_FILL});
		cmd(OP_PP, b, pd, 8'h00, 8'h00);
		cmd(OP_SUSP, 24'h000000, 8'h00, 8'h00, 8'h00);
		idle(450);
		rd(OP_RDFSR, 8'hC4, 8'hFF);
		cmd(OP_RES, 24'h000000, 8'h00, 8'h00, 8'h00);
		check_susp(1'b0);
		rd(OP_RDFSR, 8'h40, 8'hC4);
		wait_mem();
		@(posedge clk);
		lock[a[23:16]] <= 1'b1;
		cmd(OP_RES, 24'h000000, 8'h00, 8'h00, 8'h00);
		wait_mem();
		rd(OP_RDFSR, FSR_RESET, 8'hFF);
		@(posedge clk);
		lock[a[23:16]] <= 1'b0;
		$display("test nested suspend done");
		a = 24'($urandom);
		mem_q.push_back({SFE_K_SUB, a & SUB_MASK, ERASE_FILL});
		cmd(OP_SSE_B, a, 8'h00, 8'h00, 8'h00);
		idle(1700);
		cmd(OP_SUSP, 24'h000000, 8'h00, 8'h00, 8'h00);
		wait_mem();
		rd(OP_RDFSR, FSR_RESET, 8'hFF);
		$display("test short remainder done");
		a = 24'($urandom);
		cmd(OP_SE, a, 8'h00, 8'h00, 8'h00);
		cmd(OP_SUSP, 24'h000000, 8'h00, 8'h00, 8'h00);
		idle(500);
		rd(OP_RDFSR, 8'hC0, 8'hFF);
		check_susp(1'b1);
		rstn <= 1'b0;
		idle(6);
		rstn <= 1'b1;
		idle(6);
		check_susp(1'b0);
		rd(OP_RDFSR, FSR_RESET, 8'hFF);
		rd(OP_RDSR, 8'h00, 8'hFF);
		cmd(OP_RES, 24'h000000, 8'h00, 8'h00, 8'h00);
		rd(OP_RDFSR, FSR_RESET, 8'hFF);
		$display("test reset while suspended done");
		if (mem_q.size() != 0) fail("memory ops outstanding");
		results();
	end
endmodule // testbench
